/* logic/slcs_link_cfg.sv */
// Local design decision: the Avalon-MM interface to the registers.
module slcs_link_cfg (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [9:0]                    address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  input  wire logic [3:0]                    byteenable,
  output logic      [31:0]                   readdata,
  output logic                               waitrequest,
  input  wire logic                          debugEvent,
  input  wire logic                          debugCore,
  input  wire slcs_pkg::slcs_stat_type [7:0] switchLinkStat,
  input  wire slcs_pkg::slcs_stat_type [7:0] procLinkStat,
  input  wire logic [7:0]                    rxFault,
  input  wire logic [7:0]                    creditGiven,
  input  wire logic [7:0]                    creditIn,
  input  wire logic [7:0]                    symSent,
  input  wire logic [7:0]                    tokenEnd,
  output logic      [7:0]                    linkEnable,
  output logic      [7:0]                    wideMode,
  output logic      [7:0]                    greetPulse,
  output logic      [7:0]                    rxResetPulse,
  output logic      [7:0]                    txReady,
  output logic      [3:0]                    linkDir [8],
  output logic      [1:0]                    linkNet [8],
  output logic      [1:0]                    procNet [8],
  output slcs_pkg::slcs_fwd_type [7:0]       fixedFwd
);
  // ==========================================================
  // bus slave: one wait cycle, then the transfer completes
  logic [7:0]  idx;
  logic [2:0]  sel;
  logic        wrCommit;
  logic        waitReq_r;
  logic [31:0] rdWord;
  logic [1:0]  rsvPair_r;
  logic [1:0]  dbgSrc_r;
  logic        dbgRsv_r;
  logic [7:0]  err_r;
  logic [7:0]  held_r;
  logic [10:0] symGap_r [8];
  logic [10:0] tokGap_r [8];
  logic [11:0] gapCnt_r [8];
  logic [31:0] statMerge;
  logic [31:0] procMerge;
  logic [31:0] ctlMerge;

  assign idx      = address[9:2];
  assign sel      = idx[2:0];
  assign wrCommit = write & ~waitReq_r;

  function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[8*b +: 8] = wd[8*b +: 8];
    end
    return res;
  endfunction : mergeBe

  function automatic logic hitBlock(input logic [7:0] ix, input logic [7:0] base);
    return ix[7:3] == base[7:3];
  endfunction : hitBlock

  // static registers are in letter order C,D,A,B,G,H,E,F
  function automatic logic [2:0] fwdLink(input logic [2:0] regSlot);
    return regSlot ^ 3'h2;
  endfunction : fwdLink

  function automatic logic [31:0] statWord(input slcs_pkg::slcs_stat_type st,
                                           input logic [3:0] dir, input logic [1:0] net);
    logic [31:0] w;
    w = slcs_pkg::RD_ZERO;
    w[slcs_pkg::KIND_LSB +: 2] = st.kind;
    if (st.srcBusy | st.dstBusy)
      w[slcs_pkg::DEST_LSB +: 8] = st.dest;
    w[slcs_pkg::DIR_LSB +: 4] = dir;
    w[slcs_pkg::NET_LSB +: 2] = net;
    w[slcs_pkg::JUNK_BIT] = st.junk;
    w[slcs_pkg::DST_BIT]  = st.dstBusy;
    w[slcs_pkg::SRC_BIT]  = st.srcBusy;
    return w;
  endfunction : statWord

  // old fields laid out as on the bus, so lane merging lives in one function
  assign statMerge = mergeBe({20'h00000, linkDir[sel], 2'h0, linkNet[sel], 4'h0}, writedata,
                             byteenable);
  assign procMerge = mergeBe({26'h0000000, procNet[sel], 4'h0}, writedata, byteenable);
  assign ctlMerge  = mergeBe({10'h000, symGap_r[sel], tokGap_r[sel]}, writedata, byteenable);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      waitReq_r <= 1'b1;
    else
      waitReq_r <= ~((read | write) & waitReq_r);
  end

  assign waitrequest = waitReq_r;

  always_comb
  begin
    rdWord = slcs_pkg::RD_ZERO;
    if (idx == slcs_pkg::REG_RSV_PAIR)
      rdWord[1:0] = rsvPair_r;
    else if (idx == slcs_pkg::REG_DEBUG_SRC)
    begin
      rdWord[slcs_pkg::DBG_RSV_BIT] = dbgRsv_r;
      rdWord[1:0] = dbgSrc_r;
    end
    else if (hitBlock(idx, slcs_pkg::REG_LINK_STAT))
      rdWord = statWord(switchLinkStat[sel], linkDir[sel], linkNet[sel]);
    else if (hitBlock(idx, slcs_pkg::REG_PROCESSOR_LINK_STAT))
      rdWord = statWord(procLinkStat[sel], slcs_pkg::RST_DIR, procNet[sel]);
    else if (hitBlock(idx, slcs_pkg::REG_EXT_CTL))
    begin
      rdWord[slcs_pkg::EN_BIT]    = linkEnable[sel];
      rdWord[slcs_pkg::WIDE_BIT]  = wideMode[sel];
      rdWord[slcs_pkg::ERR_BIT]   = err_r[sel];
      rdWord[slcs_pkg::GIVEN_BIT] = creditGiven[sel];
      rdWord[slcs_pkg::HELD_BIT]  = held_r[sel];
      rdWord[slcs_pkg::SGAP_LSB +: slcs_pkg::GAP_W] = symGap_r[sel];
      rdWord[slcs_pkg::TGAP_LSB +: slcs_pkg::GAP_W] = tokGap_r[sel];
    end
    else if (hitBlock(idx, slcs_pkg::REG_FIXED_FWD))
    begin
      rdWord[slcs_pkg::FWD_EN_BIT] = fixedFwd[fwdLink(sel)].enable;
      rdWord[slcs_pkg::FWD_PROC]   = fixedFwd[fwdLink(sel)].proc;
      rdWord[slcs_pkg::CHAN_LSB +: 5] = fixedFwd[fwdLink(sel)].chan;
    end
  end

  // read data is caught in the wait cycle and holds through completion
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      readdata <= slcs_pkg::RD_ZERO;
    else if (read & waitReq_r)
      readdata <= rdWord;
  end

  // ==========================================================
  // debug source and reserved pair
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dbgSrc_r  <= 2'h0;
      dbgRsv_r  <= 1'b0;
      rsvPair_r <= 2'h0;
    end
    else
    begin
      if (wrCommit && idx == slcs_pkg::REG_RSV_PAIR && byteenable[0])
        rsvPair_r <= writedata[1:0];
      if (wrCommit && idx == slcs_pkg::REG_DEBUG_SRC && byteenable[0])
      begin
        dbgRsv_r <= writedata[slcs_pkg::DBG_RSV_BIT];
        dbgSrc_r <= writedata[1:0];
      end
      // a new event wins over a software write in the same cycle
      if (debugEvent)
        dbgSrc_r <= debugCore ? 2'b10 : 2'b01;
    end
  end

  // ==========================================================
  // per-link configuration
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 8; i++)
      begin
        linkDir[i] <= slcs_pkg::RST_DIR;
        linkNet[i] <= slcs_pkg::RST_NET;
        procNet[i] <= slcs_pkg::RST_NET;
      end
    end
    else if (wrCommit)
    begin
      if (hitBlock(idx, slcs_pkg::REG_LINK_STAT))
      begin
        linkDir[sel] <= statMerge[slcs_pkg::DIR_LSB +: 4];
        linkNet[sel] <= statMerge[slcs_pkg::NET_LSB +: 2];
      end
      if (hitBlock(idx, slcs_pkg::REG_PROCESSOR_LINK_STAT))
        procNet[sel] <= procMerge[slcs_pkg::NET_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      linkEnable <= 8'h00;
      wideMode   <= 8'h00;
      for (int i = 0; i < 8; i++)
      begin
        symGap_r[i] <= slcs_pkg::RST_GAP;
        tokGap_r[i] <= slcs_pkg::RST_GAP;
      end
    end
    else if (wrCommit && hitBlock(idx, slcs_pkg::REG_EXT_CTL))
    begin
      if (byteenable[3])
      begin
        linkEnable[sel] <= writedata[slcs_pkg::EN_BIT];
        wideMode[sel]   <= writedata[slcs_pkg::WIDE_BIT];
      end
      symGap_r[sel] <= ctlMerge[slcs_pkg::SGAP_LSB +: slcs_pkg::GAP_W];
      tokGap_r[sel] <= ctlMerge[slcs_pkg::TGAP_LSB +: slcs_pkg::GAP_W];
    end
  end

  // command bits: one-cycle pulses, writing zero does nothing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      greetPulse   <= 8'h00;
      rxResetPulse <= 8'h00;
    end
    else
    begin
      greetPulse   <= 8'h00;
      rxResetPulse <= 8'h00;
      if (wrCommit && hitBlock(idx, slcs_pkg::REG_EXT_CTL) && byteenable[3])
        greetPulse[sel] <= writedata[slcs_pkg::GREETING_TOKEN_BIT];
      if (wrCommit && hitBlock(idx, slcs_pkg::REG_EXT_CTL) && byteenable[2])
        rxResetPulse[sel] <= writedata[slcs_pkg::RXRST_BIT];
    end
  end

  // ==========================================================
  // link status flags
  // error stays until the receiver is reset; a fault in that cycle still lands
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_r  <= 8'h00;
      held_r <= 8'h00;
    end
    else
    begin
      err_r  <= (err_r & ~rxResetPulse) | rxFault;
      // credit from the far end wins over a local discard in the same cycle
      held_r <= (held_r & ~greetPulse) | creditIn;
    end
  end

  // ==========================================================
  // transmit pacing: counter loaded with gap+1 after each symbol
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txReady <= 8'h00;
      for (int i = 0; i < 8; i++)
        gapCnt_r[i] <= 12'h000;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (symSent[i])
        begin
          gapCnt_r[i] <= tokenEnd[i] ? {1'b0, tokGap_r[i]} + 12'h001
                                     : {1'b0, symGap_r[i]} + 12'h001;
          txReady[i]  <= 1'b0;
        end
        else
        begin
          if (gapCnt_r[i] != 12'h000)
            gapCnt_r[i] <= gapCnt_r[i] - 12'h001;
          txReady[i] <= linkEnable[i] & (gapCnt_r[i] <= 12'h001);
        end
      end
    end
  end

  // ==========================================================
  // fixed forwarding
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 8; i++)
        fixedFwd[i] <= '{enable: 1'b0, proc: 1'b0, chan: slcs_pkg::RST_CHAN};
    end
    else if (wrCommit && hitBlock(idx, slcs_pkg::REG_FIXED_FWD))
    begin
      if (byteenable[3])
        fixedFwd[fwdLink(sel)].enable <= writedata[slcs_pkg::FWD_EN_BIT];
      if (byteenable[1])
        fixedFwd[fwdLink(sel)].proc <= writedata[slcs_pkg::FWD_PROC];
      if (byteenable[0])
        fixedFwd[fwdLink(sel)].chan <= writedata[slcs_pkg::CHAN_LSB +: 5];
    end
  end

  // ==========================================================
  // assertions
  logic extWr0;
  assign extWr0 = wrCommit && idx == slcs_pkg::REG_EXT_CTL;

  property p_wait_one;
    @(posedge clk) disable iff (!rst_b)
    (read | write) && waitReq_r |=> !waitReq_r ##1 waitReq_r;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("slave did not answer in one cycle");

  property p_dbg_src;
    @(posedge clk) disable iff (!rst_b)
    debugEvent |=> dbgSrc_r == ($past(debugCore) ? 2'b10 : 2'b01);
  endproperty
  a_dbg_src: assert property (p_dbg_src) else $error("debug source wrong");

  property p_greet;
    @(posedge clk) disable iff (!rst_b)
    extWr0 && byteenable[3] && writedata[slcs_pkg::GREETING_TOKEN_BIT]
      |=> greetPulse[0] ##1 (!greetPulse[0] && (!held_r[0] || $past(creditIn[0])));
  endproperty
  a_greet: assert property (p_greet) else $error("greeting did not pulse or drop credit");

  property p_rx_reset;
    @(posedge clk) disable iff (!rst_b)
    extWr0 && byteenable[2] && writedata[slcs_pkg::RXRST_BIT] |=> rxResetPulse[0];
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receiver reset missing");

  property p_cmd_pulse;
    @(posedge clk) disable iff (!rst_b)
    rxResetPulse[0] && !$past(wrCommit) |-> 1'b0;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse without write");

  property p_err;
    @(posedge clk) disable iff (!rst_b)
    rxFault[0] |=> err_r[0];
  endproperty
  a_err: assert property (p_err) else $error("fault not flagged");

  property p_err_clr;
    @(posedge clk) disable iff (!rst_b)
    rxResetPulse[0] && !rxFault[0] |=> !err_r[0];
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error not cleared by rx reset");

  property p_sym_gap;
    @(posedge clk) disable iff (!rst_b)
    symSent[0] && !tokenEnd[0] |=> gapCnt_r[0] == {1'b0, $past(symGap_r[0])} + 12'h001;
  endproperty
  a_sym_gap: assert property (p_sym_gap) else $error("symbol gap wrong");

  property p_tok_gap;
    @(posedge clk) disable iff (!rst_b)
    symSent[0] && tokenEnd[0] |=> !txReady[0] ##1 (!txReady[0] || tokGap_r[0] == 11'h000);
  endproperty
  a_tok_gap: assert property (p_tok_gap) else $error("token gap too short");

  property p_enable;
    @(posedge clk) disable iff (!rst_b)
    extWr0 && byteenable[3] |=> linkEnable[0] == $past(writedata[slcs_pkg::EN_BIT]);
  endproperty
  a_enable: assert property (p_enable) else $error("link enable not stored");

  property p_fwd_map;
    @(posedge clk) disable iff (!rst_b)
    wrCommit && idx == slcs_pkg::REG_FIXED_FWD && byteenable[3]
      |=> fixedFwd[2].enable == $past(writedata[slcs_pkg::FWD_EN_BIT]);
  endproperty
  a_fwd_map: assert property (p_fwd_map) else $error("static slot mapping wrong");

  c_read:  cover property (@(posedge clk) disable iff (!rst_b) read && !waitReq_r);
  c_greet: cover property (@(posedge clk) disable iff (!rst_b) greetPulse[0]);
  c_gap:   cover property (@(posedge clk) disable iff (!rst_b) symSent[0] ##[2:20] txReady[0]);
endmodule : slcs_link_cfg

/* include/slcs_pkg.sv */
// What this block does
// - debug source marks which core raised debug
// - status bits 25:24 give source target kind
// - in-use link shows destination link number
// - routed link direction field, read-write, reset zero
// - network number field, read-write, reset zero
// - status bit 2 flags junk packet
// - bit 1 destination busy, bit 0 source busy
// - processor links same fields, no direction
// - eight links, one register each
// - bit 31 enables the external link
// - bit 30 picks two or five wires
// - bit 27 flags overflow or illegal token
// - bit 26 shows credit granted to remote
// - bit 25 shows credit held locally
// - bit 24 drops credit, sends greeting token
// - bit 23 resets receiver token framing
// - symbol gap is field plus one clocks
// - token gap is field plus one clocks
// - static enable forwards all packets locally
// - bit 8 processor, bits 4:0 channel end
// - static registers map to links C,D,A,B,G,H,E,F
package slcs_pkg;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam int unsigned IDX_W          = 8;
  localparam logic [7:0]  REG_RSV_PAIR   = 8'h11;
  localparam logic [7:0]  REG_DEBUG_SRC  = 8'h1f;
  localparam logic [7:0]  REG_LINK_STAT  = 8'h20;
  localparam logic [7:0]  REG_PROCESSOR_LINK_STAT = 8'h40;
  localparam logic [7:0]  REG_EXT_CTL    = 8'h80;
  localparam logic [7:0]  REG_FIXED_FWD  = 8'ha0;
  localparam int unsigned NUM_LINKS      = 8;
  // ==========================================================
  // field positions
  localparam int unsigned KIND_LSB    = 24;
  localparam int unsigned DEST_LSB    = 16;
  localparam int unsigned DIR_LSB     = 8;
  localparam int unsigned NET_LSB     = 4;
  localparam int unsigned JUNK_BIT    = 2;
  localparam int unsigned DST_BIT     = 1;
  localparam int unsigned SRC_BIT     = 0;
  localparam int unsigned DBG_RSV_BIT = 4;
  localparam int unsigned DBG_C1_BIT  = 1;
  localparam int unsigned DBG_C0_BIT  = 0;
  localparam int unsigned EN_BIT      = 31;
  localparam int unsigned WIDE_BIT    = 30;
  localparam int unsigned ERR_BIT     = 27;
  localparam int unsigned GIVEN_BIT   = 26;
  localparam int unsigned HELD_BIT    = 25;
  localparam int unsigned GREETING_TOKEN_BIT   = 24;
  localparam int unsigned RXRST_BIT   = 23;
  localparam int unsigned SGAP_LSB    = 11;
  localparam int unsigned TGAP_LSB    = 0;
  localparam int unsigned GAP_W       = 11;
  localparam int unsigned FWD_EN_BIT  = 31;
  localparam int unsigned FWD_PROC    = 8;
  localparam int unsigned CHAN_LSB    = 0;
  // ==========================================================
  // reset values
  localparam logic [3:0]  RST_DIR  = 4'h0;
  localparam logic [1:0]  RST_NET  = 2'h0;
  localparam logic [10:0] RST_GAP  = 11'h000;
  localparam logic [4:0]  RST_CHAN = 5'h00;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  // ==========================================================
  // carriers
  typedef enum logic [1:0] {
    KIND_SWITCH_LINK = 2'b00,
    KIND_PROC_LINK   = 2'b01,
    KIND_SWITCH_CTL  = 2'b10,
    KIND_UNDEFINED   = 2'b11
  } slcs_kind_type;

  typedef struct packed {
    slcs_kind_type kind;
    logic [7:0]    dest;
    logic          junk;
    logic          dstBusy;
    logic          srcBusy;
  } slcs_stat_type;

  typedef struct packed {
    logic       enable;
    logic       proc;
    logic [4:0] chan;
  } slcs_fwd_type;
endpackage : slcs_pkg

/* verif/slcs_remote_end.sv */
module slcs_remote_end (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] linkEnable,
  input  wire logic [7:0] greetPulse,
  input  wire logic [7:0] lag,
  output logic      [7:0] creditIn,
  output logic      [7:0] creditGiven
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // remote end: answers a greeting with credit after lag cycles
  logic [7:0] cnt [8];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      creditIn    <= 8'h00;
      creditGiven <= 8'h00;
      for (int i = 0; i < 8; i++)
        cnt[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        // a disabled link never sees the greeting, so no credit comes back
        creditGiven[i] <= linkEnable[i];
        creditIn[i]    <= 1'h0;
        if (greetPulse[i] && linkEnable[i])
          cnt[i] <= (lag == 8'h00) ? 8'h01 : lag;
        else if (cnt[i] > 8'h01)
          cnt[i] <= cnt[i] - 8'h01;
        else if (cnt[i] == 8'h01)
        begin
          cnt[i]      <= 8'h00;
          creditIn[i] <= 1'h1;
        end
      end
    end
  end
endmodule : slcs_remote_end

/* verif/slcs_testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  logic                          clk = 1'h0;
  logic                          rst_b = 1'h0;
  logic [9:0]                    address = 10'h000;
  logic                          read = 1'h0;
  logic                          write = 1'h0;
  logic [31:0]                   writedata = 32'h0;
  logic [3:0]                    byteenable = 4'hf;
  logic [31:0]                   readdata;
  logic                          waitrequest;
  logic                          debugEvent = 1'h0;
  logic                          debugCore = 1'h0;
  slcs_pkg::slcs_stat_type [7:0] switchLinkStat = '0;
  slcs_pkg::slcs_stat_type [7:0] procLinkStat = '0;
  logic [7:0]                    rxFault = 8'h00;
  logic [7:0]                    symSent = 8'h00;
  logic [7:0]                    tokenEnd = 8'h00;
  logic [7:0]                    lag = 8'h10;
  logic [7:0]                    creditGiven, creditIn, linkEnable, wideMode;
  logic [7:0]                    greetPulse, rxResetPulse, txReady;
  logic [3:0]                    linkDir [8];
  logic [1:0]                    linkNet [8];
  logic [1:0]                    procNet [8];
  slcs_pkg::slcs_fwd_type [7:0]  fixedFwd;
  logic [31:0]                   seed = 32'h0001_5ce9;
  logic [31:0]                   mCtl [8];
  int                            gCnt [8];
  int                            rCnt [8];
  int                            failures = 0;
  int                            nTests = 0;

  always #20 clk = ~clk;

  slcs_link_cfg dut_u (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .debugEvent(debugEvent), .debugCore(debugCore),
    .switchLinkStat(switchLinkStat), .procLinkStat(procLinkStat), .rxFault(rxFault),
    .creditGiven(creditGiven), .creditIn(creditIn), .symSent(symSent),
    .tokenEnd(tokenEnd), .linkEnable(linkEnable), .wideMode(wideMode),
    .greetPulse(greetPulse), .rxResetPulse(rxResetPulse), .txReady(txReady),
    .linkDir(linkDir), .linkNet(linkNet), .procNet(procNet), .fixedFwd(fixedFwd));

  slcs_remote_end far_u (.clk(clk), .rst_b(rst_b), .linkEnable(linkEnable),
    .greetPulse(greetPulse), .lag(lag), .creditIn(creditIn), .creditGiven(creditGiven));

  // command pulses are counted, so a stuck or doubled pulse shows as a wrong count
  always @(posedge clk)
    for (int i = 0; i < 8; i++)
    begin
      if (greetPulse[i] === 1'h1) gCnt[i]++;
      if (rxResetPulse[i] === 1'h1) rCnt[i]++;
    end

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [31:0] statw(slcs_pkg::slcs_stat_type s, logic [3:0] dr,
                                        logic [1:0] nt);
    logic [7:0] dst;
    dst = (s.srcBusy | s.dstBusy) ? s.dest : 8'h00;
    return {6'h00, s.kind, dst, 4'h0, dr, 2'h0, nt, 1'h0, s.junk, s.dstBusy, s.srcBusy};
  endfunction : statw

  task automatic final_report();
    if (failures == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address    <= {idx, 2'h0};
    read       <= ~wr;
    write      <= wr;
    writedata  <= d;
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'h0 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    q = readdata;
    read  <= 1'h0;
    write <= 1'h0;
    if (n >= 50)
    begin
      failures++;
      final_report();
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(idx, 1'h1, d, 4'hf, q);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] q;
    bus(idx, 1'h0, 32'h0, 4'hf, q);
    chk(what, e, q);
  endtask : rd

  task automatic pace(input int i, input logic tok, input int gap);
    int n;
    n = 0;
    @(posedge clk);
    symSent[i]  <= 1'h1;
    tokenEnd[i] <= tok;
    @(posedge clk);
    symSent[i]  <= 1'h0;
    tokenEnd[i] <= 1'h0;
    @(negedge clk);
    while (txReady[i] === 1'h0 && n < 3000)
    begin
      n++;
      @(negedge clk);
    end
    chk("idle gap", gap + 1, n);
  endtask : pace

  // ==========================================================
  // tests
  initial
  begin
    logic [31:0] d;
    logic [10:0] sg;
    logic [10:0] tg;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      rd("link status", 8'h20 + i[7:0], 32'h0);
      rd("proc status", 8'h40 + i[7:0], 32'h0);
      rd("link control", 8'h80 + i[7:0], 32'h0);
      rd("fixed forward", 8'ha0 + i[7:0], 32'h0);
    end
    rd("unmapped", 8'h28, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      d = rnd();
      switchLinkStat[i] <= slcs_pkg::slcs_stat_type'({i[1:0], d[31:24], d[2:0]});
      procLinkStat[i] <= slcs_pkg::slcs_stat_type'({d[17:16], d[15:8], d[14:12]});
      wr(8'h20 + i[7:0], d);
      wr(8'h40 + i[7:0], ~d);
      rd("link status", 8'h20 + i[7:0], statw(switchLinkStat[i], d[11:8], d[5:4]));
      rd("proc status", 8'h40 + i[7:0], statw(procLinkStat[i], 4'h0, ~d[5:4]));
      chk("link dir", {28'h0, d[11:8]}, {28'h0, linkDir[i]});
      chk("link net", {30'h0, d[5:4]}, {30'h0, linkNet[i]});
      chk("proc net", {30'h0, ~d[5:4]}, {30'h0, procNet[i]});
    end
    for (int c = 0; c < 2; c++)
    begin
      @(posedge clk);
      debugEvent <= 1'h1;
      debugCore  <= c[0];
      @(posedge clk);
      debugEvent <= 1'h0;
      rd("debug source", 8'h1f, 32'h1 << c);
    end
    for (int i = 0; i < 8; i++)
    begin
      d = rnd();
      sg = {8'h00, d[2:0]};
      tg = (i == 7) ? 11'h7ff : {7'h00, d[7:4]};
      lag <= 8'h0c + i[7:0];
      mCtl[i] = {1'h1, i[0], 8'h00, sg, tg};
      wr(8'h80 + i[7:0], mCtl[i] | 32'h0800_0000);
      // the write lands at the completing edge; look once the outputs have settled
      @(negedge clk);
      chk("enable", 32'h1, {31'h0, linkEnable[i]});
      chk("wide", {31'h0, i[0]}, {31'h0, wideMode[i]});
      rd("link control", 8'h80 + i[7:0], mCtl[i] | 32'h0400_0000);
      pace(i, 1'h0, sg);
      pace(i, 1'h1, tg);
      wr(8'h80 + i[7:0], mCtl[i] | 32'h0100_0000);
      rd("credit dropped", 8'h80 + i[7:0], mCtl[i] | 32'h0400_0000);
      chk("greeting pulses", 32'h1, gCnt[i]);
      for (int n = 0; n < 100 && creditIn[i] !== 1'h1; n++)
        @(posedge clk);
      rd("credit held", 8'h80 + i[7:0], mCtl[i] | 32'h0600_0000);
      @(posedge clk);
      rxFault[i] <= 1'h1;
      @(posedge clk);
      rxFault[i] <= 1'h0;
      rd("link error", 8'h80 + i[7:0], mCtl[i] | 32'h0e00_0000);
      wr(8'h80 + i[7:0], mCtl[i] | 32'h0080_0000);
      rd("rx reset", 8'h80 + i[7:0], mCtl[i] | 32'h0600_0000);
      chk("rx reset pulses", 32'h1, rCnt[i]);
      // lane 3 left out: enable and width must survive
      bus(8'h80 + i[7:0], 1'h1, 32'h0, 4'h7, d);
      mCtl[i] = mCtl[i] & 32'hff00_0000;
      rd("lane write", 8'h80 + i[7:0], mCtl[i] | 32'h0600_0000);
    end
    for (int k = 0; k < 8; k++)
    begin
      d = rnd();
      wr(8'ha0 + k[7:0], d);
      rd("fixed forward", 8'ha0 + k[7:0], d & 32'h8000_011f);
      chk("forward port", {25'h0, d[31], d[8], d[4:0]}, {25'h0, fixedFwd[k ^ 2]});
    end
    final_report();
  end

  initial
  begin
    #(40 * 40000);
    failures++;
    final_report();
  end
endmodule : testbench
